// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic               sys_clk;
    logic               rst;
    rcr_pkg::rcr_req_s  bus_req;
    logic [7:0]         rd_data;
    logic [7:0]         signal_raw;
    logic [8:0]         signal_trimmed;
    logic               monitor_buffer_enable;
    logic [2:0]         converter_input_select;
    logic               conv_route_valid;
    logic               rate_limit_enable;
    rcr_pkg::rcr_rate_s rate_window;
    int                 n_mismatch;
    int                 tests_run;
    logic [7:0]         rv;

    rcr_cfg_regs uut (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
        .signal_raw(signal_raw), .signal_trimmed(signal_trimmed),
        .monitor_buffer_enable(monitor_buffer_enable), .converter_input_select(converter_input_select),
        .conv_route_valid(conv_route_valid), .rate_limit_enable(rate_limit_enable),
        .rate_window(rate_window));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // A gap edge after each strobe keeps every assignment in its own time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 rv = rd_data;
        chk(17'(rv), 17'(e));
    endtask : rdchk

    // Write then read one register with no idle cycle between the strobes
    task automatic wrrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 rv = rd_data;
        chk(17'(rv), 17'(e));
    endtask : wrrd

    // Trim output lags its inputs by one registered stage
    task automatic trim(input logic [7:0] o, input logic [7:0] s, input logic [7:0] r, input logic [8:0] e);
        wr(8'h90, o);
        wr(8'h91, s);
        @(posedge sys_clk);
        signal_raw <= r;
        repeat (2) @(posedge sys_clk);
        #1 chk(17'(signal_trimmed), 17'(e));
    endtask : trim

    task automatic conclude;
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    initial begin
        rst = 1'b1;
        bus_req = '0;
        signal_raw = 8'h00;
        rate_limit_enable = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        #1 chk(17'({monitor_buffer_enable, converter_input_select, conv_route_valid}), 17'h11);
        chk(17'(rate_window), 17'h0);
        rdchk(8'h8E, 8'h01);
        rdchk(8'h8F, 8'h00);
        rdchk(8'h90, 8'h80);
        rdchk(8'h91, 8'h80);
        rdchk(8'h92, 8'h1E);
        rdchk(8'h93, 8'h23);
        $display("reset test done");
        wr(8'h8E, 8'hFE);
        chk(17'(monitor_buffer_enable), 17'h0);
        rdchk(8'h8E, 8'h00);
        wr(8'h8E, 8'h01);
        chk(17'(monitor_buffer_enable), 17'h1);
        $display("monitor test done");
        for (int i = 0; i < 8; i++) begin
            wr(8'h8F, 8'hF8 | 8'(i));
            @(posedge sys_clk);
            #1 chk(17'({converter_input_select, conv_route_valid}), 17'({3'(i), i < 3}));
            rdchk(8'h8F, 8'(i));
        end
        $display("select test done");
        trim(8'h80, 8'h80, 8'h40, 9'h040);
        trim(8'h00, 8'h80, 8'h40, 9'h000);
        trim(8'h81, 8'h80, 8'h40, 9'h042);
        trim(8'h7F, 8'h80, 8'h40, 9'h03E);
        trim(8'h80, 8'h40, 8'hC8, 9'h064);
        trim(8'hFF, 8'hFF, 8'hFF, 9'h1FF);
        trim(8'hFF, 8'h00, 8'h40, 9'h0FE);
        trim(8'h00, 8'hFF, 8'hFF, 9'h0FC);
        $display("trim test done");
        wr(8'h92, 8'h55);
        wr(8'h93, 8'hAA);
        rdchk(8'h92, 8'h55);
        rdchk(8'h93, 8'hAA);
        chk(17'(rate_window), 17'h0);
        @(posedge sys_clk);
        rate_limit_enable <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 chk(17'(rate_window), {1'b1, 8'h55, 8'hAA});
        @(posedge sys_clk);
        rate_limit_enable <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 chk(17'(rate_window), 17'h0);
        $display("rate test done");
        wr(8'h94, 8'hFF);
        rdchk(8'h94, 8'h00);
        wr(8'h8D, 8'hFF);
        rdchk(8'h8D, 8'h00);
        rdchk(8'h8E, 8'h01);
        wrrd(8'h90, 8'h3C, 8'h3C);
        wrrd(8'h8F, 8'hFA, 8'h02);
        $display("unmapped test done");
        conclude();
    end
endmodule : tb_top

// >>> hw/rcr_cfg_regs.sv
// Local design decision: strobed register access.
`timescale 1ns/1ps
module rcr_cfg_regs (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Register port
    input  wire rcr_pkg::rcr_req_s bus_req,
    output logic [7:0]             rd_data,
    // Signal-strength path
    input  wire logic [7:0]        signal_raw,
    output logic [8:0]             signal_trimmed,
    output logic                   monitor_buffer_enable,
    // Converter input routing
    output logic [2:0]             converter_input_select,
    output logic                   conv_route_valid,
    // Clock recovery window
    input  wire logic              rate_limit_enable,
    output rcr_pkg::rcr_rate_s     rate_window
);

    logic       mon_en_r,  mon_en_nxt;
    logic [2:0] sel_r,     sel_nxt;
    logic [7:0] offs_r,    offs_nxt;
    logic [7:0] slope_r,   slope_nxt;
    logic [7:0] up_r,      up_nxt;
    logic [7:0] lo_r,      lo_nxt;
    logic [7:0] rd_r,      rd_nxt;
    logic [8:0] trim_r,    trim_nxt;
    logic       valid_r,   valid_nxt;
    logic [5:0] wr_hit,    rd_hit;
    rcr_pkg::rcr_rate_s win_r, win_nxt;

    logic signed [10:0] offs_val;
    logic        [15:0] prod;
    logic signed [10:0] sum;

    // Gain then offset, result clamped to 9 bits
    always_comb begin
        offs_val = 11'(signed'({1'b0, offs_r, 1'b0})) - 11'sh100;
        prod     = 16'(signal_raw) * 16'(slope_r);
        sum      = 11'(signed'({3'h0, prod[15:rcr_pkg::SLOPE_SHIFT]})) + offs_val;
        if (sum < 11'sh000) begin
            trim_nxt = 9'h000;
        end else if (sum > 11'sh1FF) begin
            trim_nxt = 9'h1FF;
        end else begin
            trim_nxt = sum[8:0];
        end
    end

    // One-hot register hit, shared by writes and reads; unmapped gives zero
    function automatic logic [5:0] reg_hit(input logic [7:0] addr);
        logic [5:0] hit;
        hit = 6'h00;
        if (addr == rcr_pkg::OFS_MON_CFG) begin
            hit = 6'h01;
        end else if (addr == rcr_pkg::OFS_CONV_SEL) begin
            hit = 6'h02;
        end else if (addr == rcr_pkg::OFS_OFFS_TRIM) begin
            hit = 6'h04;
        end else if (addr == rcr_pkg::OFS_SLOPE) begin
            hit = 6'h08;
        end else if (addr == rcr_pkg::OFS_RATE_UP) begin
            hit = 6'h10;
        end else if (addr == rcr_pkg::OFS_RATE_LO) begin
            hit = 6'h20;
        end
        return hit;
    endfunction : reg_hit

    // Register writes and readback
    always_comb begin
        wr_hit     = bus_req.wr ? reg_hit(bus_req.addr) : 6'h00;
        rd_hit     = bus_req.rd ? reg_hit(bus_req.addr) : 6'h00;
        mon_en_nxt = mon_en_r;
        sel_nxt    = sel_r;
        offs_nxt   = offs_r;
        slope_nxt  = slope_r;
        up_nxt     = up_r;
        lo_nxt     = lo_r;
        // Only the field width is stored, so reserved bits never reach the device
        if (wr_hit[0]) begin
            mon_en_nxt = bus_req.wdata[rcr_pkg::MON_EN_BIT];
        end
        if (wr_hit[1]) begin
            sel_nxt = bus_req.wdata[rcr_pkg::SEL_MSB:0];
        end
        if (wr_hit[2]) begin
            offs_nxt = bus_req.wdata;
        end
        if (wr_hit[3]) begin
            slope_nxt = bus_req.wdata;
        end
        if (wr_hit[4]) begin
            up_nxt = bus_req.wdata;
        end
        if (wr_hit[5]) begin
            lo_nxt = bus_req.wdata;
        end
        // Read data stands for one cycle only, zero otherwise
        rd_nxt = 8'h00;
        if (rd_hit[0]) begin
            rd_nxt = {7'h00, mon_en_r};
        end else if (rd_hit[1]) begin
            rd_nxt = {5'h00, sel_r};
        end else if (rd_hit[2]) begin
            rd_nxt = offs_r;
        end else if (rd_hit[3]) begin
            rd_nxt = slope_r;
        end else if (rd_hit[4]) begin
            rd_nxt = up_r;
        end else if (rd_hit[5]) begin
            rd_nxt = lo_r;
        end
        // Unused select codes route nothing
        case (sel_r)
            rcr_pkg::RCR_SEL_SIGNAL,
            rcr_pkg::RCR_SEL_TEMP,
            rcr_pkg::RCR_SEL_SUPPLY: valid_nxt = 1'b1;
            default:                 valid_nxt = 1'b0;
        endcase
        // Zero window means no limiting downstream
        win_nxt.limit_on = rate_limit_enable;
        win_nxt.upper    = rate_limit_enable ? up_r : 8'h00;
        win_nxt.lower    = rate_limit_enable ? lo_r : 8'h00;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mon_en_r <= rcr_pkg::RST_MON_CFG[rcr_pkg::MON_EN_BIT];
            sel_r    <= rcr_pkg::RST_CONV_SEL[rcr_pkg::SEL_MSB:0];
            offs_r   <= rcr_pkg::RST_OFFS_TRIM;
            slope_r  <= rcr_pkg::RST_SLOPE;
            up_r     <= rcr_pkg::RST_RATE_UP;
            lo_r     <= rcr_pkg::RST_RATE_LO;
            rd_r     <= 8'h00;
            trim_r   <= 9'h000;
            valid_r  <= 1'b1;
            win_r    <= '0;
        end else begin
            mon_en_r <= mon_en_nxt;
            sel_r    <= sel_nxt;
            offs_r   <= offs_nxt;
            slope_r  <= slope_nxt;
            up_r     <= up_nxt;
            lo_r     <= lo_nxt;
            rd_r     <= rd_nxt;
            trim_r   <= trim_nxt;
            valid_r  <= valid_nxt;
            win_r    <= win_nxt;
        end
    end

    assign rd_data                = rd_r;
    assign signal_trimmed         = trim_r;
    assign monitor_buffer_enable  = mon_en_r;
    assign converter_input_select = sel_r;
    assign conv_route_valid       = valid_r;
    assign rate_window            = win_r;

    // Reset checks carry no disable so they watch the reset edge itself
    monitor_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        bus_req.wr && bus_req.addr == rcr_pkg::OFS_MON_CFG |=> monitor_buffer_enable == $past(bus_req.wdata[0]))
        else $error("monitor enable not written");
    monitor_reset_a: assert property (@(posedge sys_clk) rst |=> monitor_buffer_enable)
        else $error("monitor enable not set by reset");
    monitor_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        bus_req.rd && bus_req.addr == rcr_pkg::OFS_MON_CFG
        |=> rd_data == {7'h00, $past(monitor_buffer_enable)})
        else $error("monitor readback upper bits not zero");
    select_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        bus_req.wr && bus_req.addr == rcr_pkg::OFS_CONV_SEL
        |=> converter_input_select == $past(bus_req.wdata[2:0]))
        else $error("select field not written");
    select_unused_a: assert property (@(posedge sys_clk) disable iff (rst)
        bus_req.rd && bus_req.addr == rcr_pkg::OFS_CONV_SEL |=> rd_data[7:3] == 5'h00)
        else $error("select upper bits not zero");
    route_valid_a: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 conv_route_valid == ($past(converter_input_select) <= 3'h2))
        else $error("route valid wrong");
    unity_trim_a: assert property (@(posedge sys_clk) disable iff (rst)
        offs_r == 8'h80 && slope_r == 8'h80 && $stable(offs_r) && $stable(slope_r)
        |=> signal_trimmed == 9'($past(signal_raw)))
        else $error("unity trim not passthrough");
    offset_max_a: assert property (@(posedge sys_clk) disable iff (rst)
        offs_r == 8'hFF && slope_r == 8'h00 |=> signal_trimmed == 9'h0FE)
        else $error("offset max not 254");
    offset_floor_a: assert property (@(posedge sys_clk) disable iff (rst)
        offs_r == 8'h00 && slope_r == 8'hFF && signal_raw == 8'hFF |=> signal_trimmed == 9'h0FC)
        else $error("offset min not minus 256");
    upper_reset_a: assert property (@(posedge sys_clk) rst |=> up_r == rcr_pkg::RST_RATE_UP)
        else $error("upper threshold reset wrong");
    lower_reset_a: assert property (@(posedge sys_clk) rst |=> lo_r == rcr_pkg::RST_RATE_LO)
        else $error("lower threshold reset wrong");
    upper_pass_a: assert property (@(posedge sys_clk) disable iff (rst)
        rate_limit_enable |=> rate_window.limit_on && rate_window.upper == $past(up_r))
        else $error("upper threshold not passed");
    lower_pass_a: assert property (@(posedge sys_clk) disable iff (rst)
        rate_limit_enable |=> rate_window.lower == $past(lo_r))
        else $error("lower threshold not passed");
    limit_off_a: assert property (@(posedge sys_clk) disable iff (rst)
        !rate_limit_enable |=> !rate_window.limit_on && rate_window.upper == 8'h00 && rate_window.lower == 8'h00)
        else $error("window active while limit off");
    unmapped_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        bus_req.rd && (bus_req.addr < rcr_pkg::OFS_MON_CFG || bus_req.addr > rcr_pkg::OFS_RATE_LO)
        |=> rd_data == 8'h00)
        else $error("unmapped read not zero");

    // Scenarios the bench is expected to reach
    write_read_c: cover property (@(posedge sys_clk) disable iff (rst) bus_req.wr ##1 bus_req.rd);
    unused_sel_c: cover property (@(posedge sys_clk) disable iff (rst) !conv_route_valid);
    limit_on_c:   cover property (@(posedge sys_clk) disable iff (rst) rate_window.limit_on);
    offset_floor_c: cover property (@(posedge sys_clk) disable iff (rst) offs_r == 8'h00 && slope_r == 8'hFF);
    clamp_high_c: cover property (@(posedge sys_clk) disable iff (rst) signal_trimmed == 9'h1FF);

endmodule : rcr_cfg_regs

// >>> hw/rcr_pkg.sv
package rcr_pkg;

    // Register offsets (byte addresses on the plain port)
    localparam logic [7:0] OFS_MON_CFG   = 8'h8E;
    localparam logic [7:0] OFS_CONV_SEL  = 8'h8F;
    localparam logic [7:0] OFS_OFFS_TRIM = 8'h90;
    localparam logic [7:0] OFS_SLOPE     = 8'h91;
    localparam logic [7:0] OFS_RATE_UP   = 8'h92;
    localparam logic [7:0] OFS_RATE_LO   = 8'h93;

    // Reset values
    localparam logic [7:0] RST_MON_CFG   = 8'h01;
    localparam logic [7:0] RST_CONV_SEL  = 8'h00;
    localparam logic [7:0] RST_OFFS_TRIM = 8'h80;
    localparam logic [7:0] RST_SLOPE     = 8'h80;
    localparam logic [7:0] RST_RATE_UP   = 8'h1E;
    localparam logic [7:0] RST_RATE_LO   = 8'h23;

    // Field positions
    localparam int MON_EN_BIT  = 0;
    localparam int SEL_MSB     = 2;
    localparam int SLOPE_SHIFT = 7;

    // Converter input codes
    typedef enum logic [2:0] {
        RCR_SEL_SIGNAL = 3'h0,
        RCR_SEL_TEMP   = 3'h1,
        RCR_SEL_SUPPLY = 3'h2
    } rcr_sel_e;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rcr_req_s;

    // Rate window towards clock recovery
    typedef struct packed {
        logic       limit_on;
        logic [7:0] upper;
        logic [7:0] lower;
    } rcr_rate_s;

endpackage : rcr_pkg
